// *** rtl/string_op_engine.sv ***
// String instruction execution engine with APB register access
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
module string_op_engine (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic                           pready_o,
  output logic [31:0]                    prdata_o,
  output logic                           pslverr_o,
  output string_op_pkg::mem_req_type     mem_req_o,
  input  wire logic                      mem_ack_i,
  input  wire logic [63:0]               mem_rdata_i
);
  import string_op_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_RD_SRC, S_RD_DST, S_WR_DST, S_STEP
  } fsm_type;

  typedef struct packed {
    fsm_type     st;
    cfg_type     cfg;
    logic [63:0] src;
    logic [63:0] dst;
    logic [63:0] cnt;
    logic [63:0] acc;
    logic [63:0] sdata;
    flags_type   fl;
    mem_req_type mem;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } state_type;

  state_type s_q;
  state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic flags_type sub_flags(input logic [63:0] a, input logic [63:0] b,
                                          input logic [1:0] sz, input logic dir);
    logic [63:0] m;
    logic [63:0] r;
    logic [5:0]  hi;
    flags_type   f;
    unique case (sz)
      SZ_BYTE:  begin m = 64'h0000_0000_0000_00FF; hi = 6'h07; end
      SZ_WORD:  begin m = 64'h0000_0000_0000_FFFF; hi = 6'h0F; end
      SZ_DWORD: begin m = 64'h0000_0000_FFFF_FFFF; hi = 6'h1F; end
      default:  begin m = 64'hFFFF_FFFF_FFFF_FFFF; hi = 6'h3F; end
    endcase
    r        = (a - b) & m;
    f.carry  = (a & m) < (b & m);
    f.zero   = (r == 64'h0);
    f.sign   = r[hi];
    f.ovf    = (a[hi] ^ b[hi]) & (a[hi] ^ r[hi]);
    f.parity = ~^r[7:0];
    f.aux    = a[4] ^ b[4] ^ r[4];
    f.dir    = dir;
    return f;
  endfunction

  function automatic logic [63:0] narrow(input logic [63:0] v, input logic wide);
    return wide ? v : {32'h0000_0000, v[31:0]};
  endfunction

  logic [1:0]  esz;
  logic        wide_addr;
  logic [63:0] step;
  logic [63:0] emask;
  logic [63:0] cnt_eff;
  logic        cond_op;
  seg_type     src_seg;

  // Quad elements exist only with the wide prefix in 64-bit mode
  assign esz = (s_q.cfg.mode64 && s_q.cfg.wide) ? SZ_QWORD :
               ((s_q.cfg.size == SZ_QWORD) ? SZ_DWORD : s_q.cfg.size);
  assign wide_addr = s_q.cfg.mode64 && s_q.cfg.addr64;
  assign step      = 64'h1 << esz;
  assign emask     = (esz == SZ_QWORD) ? 64'hFFFF_FFFF_FFFF_FFFF :
                     ((64'h1 << (7'h08 << esz)) - 64'h1);
  assign cnt_eff   = narrow(s_q.cnt, wide_addr);
  assign cond_op   = (s_q.cfg.op == STRING_COMPARE) || (s_q.cfg.op == STRING_SCAN);
  assign src_seg   = (s_q.cfg.seg == SEG_NONE) ? SEG_DATA : s_q.cfg.seg;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        wr_en;
    logic [31:0] rd;
    logic        hit;
    s_d   = s_q;
    wr_en = 1'b0;
    rd    = 32'h0000_0000;
    hit   = 1'b1;
    // One wait state keeps pready and prdata registered
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    unique case (paddr_i)
      OFF_CTRL: begin
        rd[CTRL_OP_LSB +: 3]  = s_q.cfg.op;
        rd[CTRL_SZ_LSB +: 2]  = s_q.cfg.size;
        rd[CTRL_RPT_LSB +: 2] = s_q.cfg.rpt;
        rd[CTRL_SEG_LSB +: 3] = s_q.cfg.seg;
        rd[CTRL_MODE64]       = s_q.cfg.mode64;
        rd[CTRL_ADDR64]       = s_q.cfg.addr64;
        rd[CTRL_WIDE]         = s_q.cfg.wide;
      end
      OFF_STATUS: begin
        rd[ST_CARRY]  = s_q.fl.carry;
        rd[ST_PARITY] = s_q.fl.parity;
        rd[ST_AUX]    = s_q.fl.aux;
        rd[ST_ZERO]   = s_q.fl.zero;
        rd[ST_SIGN]   = s_q.fl.sign;
        rd[ST_DIR]    = s_q.fl.dir;
        rd[ST_OVF]    = s_q.fl.ovf;
        rd[ST_BUSY]   = (s_q.st != S_IDLE);
      end
      OFF_SRC_LO: rd = s_q.src[31:0];
      OFF_SRC_HI: rd = s_q.src[63:32];
      OFF_DST_LO: rd = s_q.dst[31:0];
      OFF_DST_HI: rd = s_q.dst[63:32];
      OFF_CNT_LO: rd = s_q.cnt[31:0];
      OFF_CNT_HI: rd = s_q.cnt[63:32];
      OFF_ACC_LO: rd = s_q.acc[31:0];
      OFF_ACC_HI: rd = s_q.acc[63:32];
      default:    hit = 1'b0;
    endcase
    if (psel_i && penable_i && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.prdata  = rd;
      s_d.pslverr = !hit;
    end
    wr_en = psel_i && penable_i && s_q.pready && pwrite_i && !s_q.pslverr;

    // Software writes land only while idle so a run sees stable operands
    if (wr_en && s_q.st == S_IDLE) begin
      unique case (paddr_i)
        OFF_CTRL: begin
          if (pwdata_i[CTRL_SET_DIR]) begin
            s_d.fl.dir = 1'b1;
          end else if (pwdata_i[CTRL_CLR_DIR]) begin
            s_d.fl.dir = 1'b0;
          end
          if (pwdata_i[CTRL_START]) begin
            s_d.cfg.op     = op_type'(pwdata_i[CTRL_OP_LSB +: 3]);
            s_d.cfg.size   = pwdata_i[CTRL_SZ_LSB +: 2];
            s_d.cfg.rpt    = rpt_type'(pwdata_i[CTRL_RPT_LSB +: 2]);
            s_d.cfg.seg    = seg_type'(pwdata_i[CTRL_SEG_LSB +: 3]);
            s_d.cfg.mode64 = pwdata_i[CTRL_MODE64];
            s_d.cfg.addr64 = pwdata_i[CTRL_ADDR64];
            s_d.cfg.wide   = pwdata_i[CTRL_WIDE];
            s_d.st         = S_CHECK;
          end
        end
        OFF_STATUS: begin
          s_d.fl.carry  = pwdata_i[ST_CARRY];
          s_d.fl.parity = pwdata_i[ST_PARITY];
          s_d.fl.aux    = pwdata_i[ST_AUX];
          s_d.fl.zero   = pwdata_i[ST_ZERO];
          s_d.fl.sign   = pwdata_i[ST_SIGN];
          s_d.fl.dir    = pwdata_i[ST_DIR];
          s_d.fl.ovf    = pwdata_i[ST_OVF];
        end
        OFF_SRC_LO: s_d.src[31:0]  = pwdata_i;
        OFF_SRC_HI: s_d.src[63:32] = pwdata_i;
        OFF_DST_LO: s_d.dst[31:0]  = pwdata_i;
        OFF_DST_HI: s_d.dst[63:32] = pwdata_i;
        OFF_CNT_LO: s_d.cnt[31:0]  = pwdata_i;
        OFF_CNT_HI: s_d.cnt[63:32] = pwdata_i;
        OFF_ACC_LO: s_d.acc[31:0]  = pwdata_i;
        OFF_ACC_HI: s_d.acc[63:32] = pwdata_i;
        default: ;
      endcase
    end

    unique case (s_q.st)
      S_IDLE: ;
      S_CHECK: begin
        s_d.mem.size  = esz;
        s_d.mem.wdata = 64'h0;
        if (s_q.cfg.rpt != REPEAT_NONE && cnt_eff == 64'h0) begin
          s_d.st = S_IDLE;
        end else begin
          unique case (s_q.cfg.op)
            STRING_MOVE, STRING_COMPARE, STRING_LOAD: begin
              s_d.mem.valid = 1'b1;
              s_d.mem.write = 1'b0;
              s_d.mem.seg   = src_seg;
              s_d.mem.addr  = narrow(s_q.src, wide_addr);
              s_d.st        = S_RD_SRC;
            end
            STRING_SCAN: begin
              s_d.mem.valid = 1'b1;
              s_d.mem.write = 1'b0;
              s_d.mem.seg   = SEG_EXTRA;
              s_d.mem.addr  = narrow(s_q.dst, wide_addr);
              s_d.st        = S_RD_DST;
            end
            STRING_STORE: begin
              s_d.mem.valid = 1'b1;
              s_d.mem.write = 1'b1;
              s_d.mem.seg   = SEG_EXTRA;
              s_d.mem.addr  = narrow(s_q.dst, wide_addr);
              s_d.mem.wdata = s_q.acc & emask;
              s_d.st        = S_WR_DST;
            end
            default: s_d.st = S_IDLE;
          endcase
        end
      end
      S_RD_SRC: begin
        if (mem_ack_i) begin
          s_d.mem.valid = 1'b0;
          s_d.sdata     = mem_rdata_i & emask;
          unique case (s_q.cfg.op)
            STRING_MOVE: begin
              s_d.mem.valid = 1'b1;
              s_d.mem.write = 1'b1;
              s_d.mem.seg   = SEG_EXTRA;
              s_d.mem.addr  = narrow(s_q.dst, wide_addr);
              s_d.mem.wdata = mem_rdata_i & emask;
              s_d.st        = S_WR_DST;
            end
            STRING_COMPARE: begin
              s_d.mem.valid = 1'b1;
              s_d.mem.write = 1'b0;
              s_d.mem.seg   = SEG_EXTRA;
              s_d.mem.addr  = narrow(s_q.dst, wide_addr);
              s_d.st        = S_RD_DST;
            end
            default: begin
              // Dword loads in 64-bit mode zero the upper half
              unique case (esz)
                SZ_BYTE:  s_d.acc[7:0]  = mem_rdata_i[7:0];
                SZ_WORD:  s_d.acc[15:0] = mem_rdata_i[15:0];
                SZ_DWORD: s_d.acc = narrow({s_q.acc[63:32], mem_rdata_i[31:0]},
                                           !s_q.cfg.mode64);
                default:  s_d.acc = mem_rdata_i;
              endcase
              s_d.st = S_STEP;
            end
          endcase
        end
      end
      S_RD_DST: begin
        if (mem_ack_i) begin
          s_d.mem.valid = 1'b0;
          s_d.fl = sub_flags((s_q.cfg.op == STRING_COMPARE) ? s_q.sdata : s_q.acc,
                             mem_rdata_i, esz, s_q.fl.dir);
          s_d.st = S_STEP;
        end
      end
      S_WR_DST: begin
        if (mem_ack_i) begin
          s_d.mem.valid = 1'b0;
          s_d.mem.write = 1'b0;
          s_d.st        = S_STEP;
        end
      end
      S_STEP: begin
        s_d.src = narrow(s_q.fl.dir ? s_q.src - step : s_q.src + step, wide_addr);
        s_d.dst = narrow(s_q.fl.dir ? s_q.dst - step : s_q.dst + step, wide_addr);
        if (s_q.cfg.rpt == REPEAT_NONE) begin
          s_d.st = S_IDLE;
        end else begin
          s_d.cnt = narrow(cnt_eff - 64'h1, wide_addr);
          s_d.st  = S_CHECK;
          if (cond_op && s_q.cfg.rpt == REPEAT_WHILE_EQUAL && !s_q.fl.zero) begin
            s_d.st = S_IDLE;
          end
          if (cond_op && s_q.cfg.rpt == REPEAT_WHILE_NOT_EQUAL && s_q.fl.zero) begin
            s_d.st = S_IDLE;
          end
        end
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_o  = s_q.pready;
  assign prdata_o  = s_q.prdata;
  assign pslverr_o = s_q.pslverr;
  assign mem_req_o = s_q.mem;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_dst_seg;
    s_q.mem.valid && (s_q.st == S_RD_DST || s_q.st == S_WR_DST) |-> s_q.mem.seg == SEG_EXTRA;
  endproperty
  a_dst_seg: assert property (p_dst_seg) else $error("destination not in extra segment");

  property p_src_seg;
    s_q.st == S_RD_SRC && s_q.mem.valid && s_q.cfg.seg == SEG_NONE |-> s_q.mem.seg == SEG_DATA;
  endproperty
  a_src_seg: assert property (p_src_seg) else $error("source default segment wrong");

  property p_cmp_nowrite;
    s_q.cfg.op == STRING_COMPARE && s_q.st != S_IDLE |-> !s_q.mem.write;
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote memory");

  property p_scan_acc;
    s_q.st == S_RD_DST && s_q.cfg.op == STRING_SCAN |=> $stable(s_q.acc);
  endproperty
  a_scan_acc: assert property (p_scan_acc) else $error("scan changed accumulator");

  property p_load_byte;
    s_q.st == S_RD_SRC && mem_ack_i && s_q.cfg.op == STRING_LOAD && esz == SZ_BYTE
      |=> s_q.acc[7:0] == $past(mem_rdata_i[7:0]) && s_q.acc[63:8] == $past(s_q.acc[63:8]);
  endproperty
  a_load_byte: assert property (p_load_byte) else $error("byte load wrong");

  property p_step_up;
    s_q.st == S_STEP && !s_q.fl.dir && wide_addr |=> s_q.dst == $past(s_q.dst) + $past(step);
  endproperty
  a_step_up: assert property (p_step_up) else $error("pointer increment wrong");

  property p_count_dec;
    s_q.st == S_STEP && s_q.cfg.rpt != REPEAT_NONE && wide_addr
      |=> s_q.cnt == $past(s_q.cnt) - 64'h1;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");

  property p_zero_count;
    s_q.st == S_CHECK && s_q.cfg.rpt != REPEAT_NONE && cnt_eff == 64'h0
      |=> s_q.st == S_IDLE && !s_q.mem.valid;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("ran with zero count");

  property p_eq_stop;
    s_q.st == S_STEP && cond_op && s_q.cfg.rpt == REPEAT_WHILE_EQUAL && !s_q.fl.zero
      |=> s_q.st == S_IDLE;
  endproperty
  a_eq_stop: assert property (p_eq_stop) else $error("equal repeat did not stop");

  property p_ne_stop;
    s_q.st == S_STEP && cond_op && s_q.cfg.rpt == REPEAT_WHILE_NOT_EQUAL && s_q.fl.zero
      |=> s_q.st == S_IDLE;
  endproperty
  a_ne_stop: assert property (p_ne_stop) else $error("not-equal repeat kept on");

  property p_quad_only64;
    s_q.mem.valid && s_q.mem.size == SZ_QWORD |-> s_q.cfg.mode64 && s_q.cfg.wide;
  endproperty
  a_quad_only64: assert property (p_quad_only64) else $error("quad outside 64-bit mode");

endmodule // string_op_engine
`default_nettype wire

// *** rtl/string_op_pkg.sv ***
// Constants, types and register map of the string operation engine
`default_nettype none
package string_op_pkg;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SRC_LO = 8'h08;
  localparam logic [7:0] OFF_SRC_HI = 8'h0C;
  localparam logic [7:0] OFF_DST_LO = 8'h10;
  localparam logic [7:0] OFF_DST_HI = 8'h14;
  localparam logic [7:0] OFF_CNT_LO = 8'h18;
  localparam logic [7:0] OFF_CNT_HI = 8'h1C;
  localparam logic [7:0] OFF_ACC_LO = 8'h20;
  localparam logic [7:0] OFF_ACC_HI = 8'h24;
  // Control word fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_SET_DIR = 1;
  localparam int CTRL_CLR_DIR = 2;
  localparam int CTRL_OP_LSB  = 4;
  localparam int CTRL_SZ_LSB  = 8;
  localparam int CTRL_RPT_LSB = 12;
  localparam int CTRL_SEG_LSB = 16;
  localparam int CTRL_MODE64  = 20;
  localparam int CTRL_ADDR64  = 21;
  localparam int CTRL_WIDE    = 22;
  // Status word fields
  localparam int ST_CARRY  = 0;
  localparam int ST_PARITY = 2;
  localparam int ST_AUX    = 4;
  localparam int ST_ZERO   = 6;
  localparam int ST_SIGN   = 7;
  localparam int ST_DIR    = 10;
  localparam int ST_OVF    = 11;
  localparam int ST_BUSY   = 31;
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_QWORD = 2'h3;
  typedef enum logic [2:0] {
    STRING_MOVE, STRING_COMPARE, STRING_SCAN, STRING_LOAD, STRING_STORE
  } op_type;
  typedef enum logic [1:0] {
    REPEAT_NONE, REPEAT_ON_COUNT, REPEAT_WHILE_EQUAL, REPEAT_WHILE_NOT_EQUAL
  } rpt_type;
  typedef enum logic [2:0] {
    SEG_NONE, SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA, SEG_ADDL1, SEG_ADDL2
  } seg_type;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  seg;
    logic [1:0]  size;
    logic [63:0] addr;
    logic [63:0] wdata;
  } mem_req_type;
  typedef struct packed {
    logic carry;
    logic parity;
    logic aux;
    logic zero;
    logic sign;
    logic ovf;
    logic dir;
  } flags_type;
  typedef struct packed {
    op_type     op;
    logic [1:0] size;
    rpt_type    rpt;
    seg_type    seg;
    logic       mode64;
    logic       addr64;
    logic       wide;
  } cfg_type;
endpackage : string_op_pkg
`default_nettype wire

// *** dv/mem_model.sv ***
// Behavioural data memory answering the engine's memory requests
`default_nettype none
module mem_model (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [3:0]                lat_i,
  input  wire string_op_pkg::mem_req_type req_i,
  output logic                           ack_o,
  output logic [63:0]                    rdata_o
);
  import string_op_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [63:0]];
  logic [3:0] wait_q;
  logic [2:0] rseg;
  logic [2:0] wseg;
  int         rd_cnt = 0;
  int         wr_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Unused lanes carry a fixed filler so a missing mask shows
  function automatic logic [63:0] rd_elem(logic [63:0] a, logic [1:0] sz);
    logic [63:0] v;
    v = {8{8'hA5}};
    for (int i = 0; i < (1 << sz); i++) begin
      v[8*i +: 8] = mem.exists(a + i) ? mem[a + i] : 8'h00;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read data toggles whenever not answering: no stale value can pass
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 64'h0;
      wait_q  <= 4'h0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i.valid && !ack_o) begin
        if (wait_q < lat_i) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q <= 4'h0;
          ack_o  <= 1'b1;
          if (req_i.write) begin
            for (int i = 0; i < (1 << req_i.size); i++) begin
              mem[req_i.addr + i] = req_i.wdata[8*i +: 8];
            end
            wr_cnt++;
            wseg <= req_i.seg;
          end else begin
            rdata_o <= rd_elem(req_i.addr, req_i.size);
            rd_cnt++;
            rseg <= req_i.seg;
          end
        end
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench of the string operation engine
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import string_op_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ack;
  logic [63:0] rdata;
  logic [3:0]  lat = 4'h0;
  mem_req_type req;
  int          fails = 0;
  int          checks = 0;

  string_op_engine u_string_op_engine (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .mem_req_o(req),
    .mem_ack_i(ack), .mem_rdata_i(rdata));
  mem_model u_mem_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lat_i(lat), .req_i(req),
    .ack_o(ack), .rdata_o(rdata));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Request held until the edge where pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("apb ready", 64'h1, 64'h0);
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic set64(logic [7:0] a, logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask

  task automatic chk_reg(string n, logic [7:0] a, logic [63:0] e);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    chk(n, e, {hi, lo});
  endtask

  // Flag bits carry, parity, aux, zero, sign, overflow
  task automatic chk_flags(logic [31:0] e);
    logic [31:0] s;
    rd(OFF_STATUS, s);
    chk("flags", 64'(e), 64'(s & 32'h8D5));
  endtask

  task automatic run(logic [31:0] c);
    logic [31:0] s;
    int          n;
    wr(OFF_CTRL, c);
    n = 0;
    do begin
      rd(OFF_STATUS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 100);
    chk("busy end", 64'h0, 64'(s[ST_BUSY]));
    if (n >= 100) print_verdict();
  endtask

  function automatic logic [31:0] ctrl(logic [2:0] op, logic [1:0] sz, logic [1:0] rp,
                                       logic [2:0] sg, logic [2:0] m);
    return 32'h1 | (32'(op) << CTRL_OP_LSB) | (32'(sz) << CTRL_SZ_LSB)
         | (32'(rp) << CTRL_RPT_LSB) | (32'(sg) << CTRL_SEG_LSB) | (32'(m) << CTRL_MODE64);
  endfunction

  task automatic put32(logic [63:0] a, logic [31:0] v);
    for (int i = 0; i < 4; i++) u_mem_model.mem[a + i] = v[8*i +: 8];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_move;
    int n;
    wr(OFF_CTRL, 32'h4);
    set64(OFF_SRC_LO, 64'h100);
    set64(OFF_DST_LO, 64'h200);
    put32(64'h100, 32'h0000005A);
    n = u_mem_model.rd_cnt + u_mem_model.wr_cnt;
    run(ctrl(STRING_MOVE, SZ_BYTE, REPEAT_NONE, SEG_NONE, 3'h0));
    chk("move data", 64'h5A, 64'(u_mem_model.mem[64'h200]));
    chk("accesses", 64'h2, 64'(u_mem_model.rd_cnt + u_mem_model.wr_cnt - n));
    chk("src seg", 64'(SEG_DATA), 64'(u_mem_model.rseg));
    chk("dst seg", 64'(SEG_EXTRA), 64'(u_mem_model.wseg));
    chk_reg("src ptr", OFF_SRC_LO, 64'h101);
    chk_reg("dst ptr", OFF_DST_LO, 64'h201);
  endtask

  // Slow memory, downward steps, override that must not reach the destination
  task automatic t_store;
    int          w;
    logic [31:0] s;
    lat <= 4'h3;
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STATUS, s);
    chk("dir set", 64'h1, 64'(s[ST_DIR]));
    set64(OFF_SRC_LO, 64'h400);
    set64(OFF_DST_LO, 64'h300);
    set64(OFF_CNT_LO, 64'h3);
    set64(OFF_ACC_LO, 64'h1234ABCD);
    w = u_mem_model.wr_cnt;
    run(ctrl(STRING_STORE, SZ_WORD, REPEAT_ON_COUNT, SEG_CODE, 3'h0));
    chk("writes", 64'h3, 64'(u_mem_model.wr_cnt - w));
    chk("last lo", 64'hCD, 64'(u_mem_model.mem[64'h2FC]));
    chk("last hi", 64'hAB, 64'(u_mem_model.mem[64'h2FD]));
    chk("dst seg", 64'(SEG_EXTRA), 64'(u_mem_model.wseg));
    chk_reg("dst ptr", OFF_DST_LO, 64'h2FA);
    chk_reg("src ptr", OFF_SRC_LO, 64'h3FA);
    chk_reg("count", OFF_CNT_LO, 64'h0);
    lat <= 4'h0;
    wr(OFF_CTRL, 32'h4);
    rd(OFF_STATUS, s);
    chk("dir clear", 64'h0, 64'(s[ST_DIR]));
  endtask

  // Second element differs: 5 - 7 borrows, stops with two counts left
  task automatic t_cmp;
    int w;
    put32(64'h500, 32'h1); put32(64'h504, 32'h5); put32(64'h508, 32'h9);
    put32(64'h600, 32'h1); put32(64'h604, 32'h7); put32(64'h608, 32'h9);
    set64(OFF_SRC_LO, 64'h500);
    set64(OFF_DST_LO, 64'h600);
    set64(OFF_CNT_LO, 64'h4);
    w = u_mem_model.wr_cnt;
    run(ctrl(STRING_COMPARE, SZ_DWORD, REPEAT_WHILE_EQUAL, SEG_NONE, 3'h0));
    chk_reg("count", OFF_CNT_LO, 64'h2);
    chk_reg("src ptr", OFF_SRC_LO, 64'h508);
    chk("no write", 64'h0, 64'(u_mem_model.wr_cnt - w));
    chk_flags(32'h91);
  endtask

  task automatic t_scan;
    int r;
    int w;
    put32(64'h700, 32'h44772211);
    set64(OFF_ACC_LO, 64'h77);
    set64(OFF_DST_LO, 64'h700);
    set64(OFF_CNT_LO, 64'h5);
    r = u_mem_model.rd_cnt;
    w = u_mem_model.wr_cnt;
    run(ctrl(STRING_SCAN, SZ_BYTE, REPEAT_WHILE_NOT_EQUAL, SEG_NONE, 3'h0));
    chk_reg("count", OFF_CNT_LO, 64'h2);
    chk_reg("dst ptr", OFF_DST_LO, 64'h703);
    chk_reg("acc kept", OFF_ACC_LO, 64'h77);
    chk("reads", 64'h3, 64'(u_mem_model.rd_cnt - r));
    chk("no write", 64'h0, 64'(u_mem_model.wr_cnt - w));
    chk_flags(32'h44);
  endtask

  // Zero count must not touch memory at all
  task automatic t_load;
    int r;
    put32(64'h800, 32'h00001234);
    set64(OFF_ACC_LO, 64'hFFFFFFFF);
    set64(OFF_SRC_LO, 64'h800);
    set64(OFF_CNT_LO, 64'h0);
    r = u_mem_model.rd_cnt;
    run(ctrl(STRING_LOAD, SZ_WORD, REPEAT_ON_COUNT, SEG_STACK, 3'h0));
    chk("zero count", 64'h0, 64'(u_mem_model.rd_cnt - r));
    chk_reg("src ptr", OFF_SRC_LO, 64'h800);
    run(ctrl(STRING_LOAD, SZ_WORD, REPEAT_NONE, SEG_STACK, 3'h0));
    chk_reg("acc", OFF_ACC_LO, 64'hFFFF1234);
    chk("src seg", 64'(SEG_STACK), 64'(u_mem_model.rseg));
    chk_reg("src ptr", OFF_SRC_LO, 64'h802);
    run(ctrl(STRING_LOAD, SZ_BYTE, REPEAT_NONE, SEG_STACK, 3'h0));
    chk_reg("byte acc", OFF_ACC_LO, 64'hFFFF1200);
  endtask

  // Zero flag set beforehand: a while-not-equal move must still run on count
  task automatic t_wide;
    int w;
    for (int i = 0; i < 16; i++) u_mem_model.mem[64'h1_0000_0000 + i] = 8'h10 + 8'(i);
    wr(OFF_STATUS, 32'h40);
    set64(OFF_SRC_LO, 64'h1_0000_0000);
    set64(OFF_DST_LO, 64'h2_0000_0000);
    set64(OFF_CNT_LO, 64'h2);
    w = u_mem_model.wr_cnt;
    run(ctrl(STRING_MOVE, SZ_DWORD, REPEAT_WHILE_NOT_EQUAL, SEG_NONE, 3'h7));
    chk("writes", 64'h2, 64'(u_mem_model.wr_cnt - w));
    chk("top byte", 64'h1F, 64'(u_mem_model.mem[64'h2_0000_000F]));
    chk_reg("src ptr", OFF_SRC_LO, 64'h1_0000_0010);
    chk_reg("dst ptr", OFF_DST_LO, 64'h2_0000_0010);
    chk_reg("count", OFF_CNT_LO, 64'h0);
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("slverr", 64'h1, 64'(e));
    chk("unmapped data", 64'h0, 64'(r));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_move();
    t_store();
    t_cmp();
    t_scan();
    t_load();
    t_wide();
    t_unmapped();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
